// File: common/fsd_defines.vh
// Constants for the fieldbus slave diagnostics block
`ifndef FSD_DEFINES_VH
`define FSD_DEFINES_VH

`define FSD_DIAG_LEN      6'h0A
`define FSD_DIAG_CODE     2'h0
`define FSD_MSG_NONE      8'h00
`define FSD_MSG_PRM_LEN   8'h12
`define FSD_MSG_CFG_LEN   8'h13
`define FSD_MSG_CFG_ENTRY 8'h14
`define FSD_MSG_BUF_CALC  8'h15
`define FSD_MSG_CFG_MISS  8'h16
`define FSD_MSG_PRM_PROJ  8'h17
`define FSD_MSG_USER_OK   8'h40
`define FSD_PRM_MAX       5'h1F
`define FSD_CTRL_VALID    0
`define FSD_CTRL_DELETE   1
`define FSD_CTRL_RESET    8'h00
`define FSD_OFS_CTRL      3'h0
`define FSD_OFS_USER      3'h1
`define FSD_BLOCK_LEN     3'h6
`define FSD_ST_CLEAR_DATA 0
`define FSD_ST_USER_PRM   2
`define FSD_ST_RESP_ACT   3
`define FSD_ST_DP_XFER    8
`define FSD_ST_PRM        9
`define FSD_ST_CFG        10
`define FSD_ST_WATCHDOG   11
`define FSD_ST_HW         12
`define FSD_ST_DP_DATA    13

`endif

// File: src/fsd_sync.v
// Two-flop synchroniser for a bus of pin-level inputs
`timescale 1ns/1ps
module fsd_sync #(
  parameter W = 1
) (
  input  wire         clk_sys,
  input  wire         rst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;

  always @(posedge clk_sys) begin
    if (rst) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end

  assign q = s2_reg;
endmodule // fsd_sync

// File: src/fsd_status.v
// Sticky communication status word
`timescale 1ns/1ps
`include "fsd_defines.vh"
module fsd_status (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        prm_ok,
  input  wire        prm_err,
  input  wire        cfg_ok,
  input  wire        cfg_err,
  input  wire        resp_active,
  input  wire        resp_timeout,
  input  wire        hw_fail,
  input  wire        xfer_err,
  input  wire        status_clr,
  output wire [15:0] status_word,
  output wire        comm_abort
);
  reg  [15:0] sticky_reg;
  reg  [15:0] sticky_next;
  wire        wd_err;
  wire        dp_fault;

  assign wd_err   = resp_active & resp_timeout;
  assign dp_fault = prm_err | cfg_err;
  assign comm_abort = dp_fault | wd_err;

  // Hardware events set, clear wipes the rest; a set in the clear cycle wins
  always @* begin
    sticky_next = status_clr ? 16'h0000 : sticky_reg;
    if (dp_fault | wd_err | xfer_err | hw_fail)
      sticky_next[`FSD_ST_CLEAR_DATA] = 1'b1;
    if (dp_fault)
      sticky_next[`FSD_ST_DP_XFER] = 1'b1;
    if (prm_err)
      sticky_next[`FSD_ST_PRM] = 1'b1;
    if (cfg_err)
      sticky_next[`FSD_ST_CFG] = 1'b1;
    if (wd_err)
      sticky_next[`FSD_ST_WATCHDOG] = 1'b1;
    if (hw_fail)
      sticky_next[`FSD_ST_HW] = 1'b1;
    if (xfer_err)
      sticky_next[`FSD_ST_DP_DATA] = 1'b1;
  end

  always @(posedge clk_sys) begin
    if (rst)
      sticky_reg <= 16'h0000;
    else
      sticky_reg <= sticky_next;
  end

  // Live bits 2 and 3, live cfg_ok ORed into sticky bit 10, sticky bits elsewhere
  assign status_word = {sticky_reg[15:11],
                        cfg_ok | sticky_reg[`FSD_ST_CFG],
                        sticky_reg[9:4],
                        resp_active,
                        prm_ok,
                        sticky_reg[1:0]};
endmodule // fsd_status

// File: src/fsd_diag.v
// Fieldbus slave diagnostics: telegram bytes, image block and status area
`timescale 1ns/1ps
`include "fsd_defines.vh"
module fsd_diag #(
  parameter AW = 10
) (
  input  wire          clk_sys,
  input  wire          rst,
  // CPU side of the six-byte diagnostic block
  input  wire          cpu_wr,
  input  wire [2:0]    cpu_ofs,
  input  wire [7:0]    cpu_wdata,
  input  wire          cpu_rd,
  output reg  [7:0]    cpu_rdata,
  output wire [15:0]   comm_status,
  input  wire          status_clr,
  // Image block mirror
  input  wire [AW-1:0] diag_base,
  output reg           img_we,
  output reg  [AW-1:0] img_addr,
  output reg  [7:0]    img_wdata,
  // Events from the protocol controller (asynchronous)
  input  wire          prm_done,
  input  wire [4:0]    prm_len_decl,
  input  wire [5:0]    prm_count,
  input  wire          cfg_ok_in,
  input  wire [7:0]    cfg_err_code,
  input  wire          resp_active_in,
  input  wire          resp_timeout_in,
  input  wire          hw_fail_in,
  input  wire          xfer_err_in,
  input  wire          master_diag_req,
  // Telegram toward the master
  output reg           diag_send,
  input  wire          diag_busy,
  output reg  [7:0]    diag_byte6,
  output reg  [7:0]    diag_byte7,
  output reg  [39:0]   diag_user,
  output wire          comm_abort,
  output wire          buf_clear
);
  localparam ST_IDLE = 2'h0;
  localparam ST_MIRR = 2'h1;
  localparam ST_SEND = 2'h2;

  reg  [7:0]  ctrl_reg;
  reg  [39:0] user_reg;
  reg  [7:0]  msg_reg;
  reg  [7:0]  msg_next;
  reg  [1:0]  state_reg;
  reg  [2:0]  idx_reg;
  reg         pend_reg;
  reg         err_d_reg;
  reg  [7:0]  ctrl_next;
  wire [6:0]  sync_in;
  wire [4:0]  prm_len_s;
  wire [5:0]  prm_cnt_s;
  wire        prm_done_s;
  wire        resp_act_s;
  wire        resp_to_s;
  wire        hw_fail_s;
  wire        xfer_err_s;
  wire        req_s;
  wire        cfg_ok_s;
  wire        cfg_err_s;
  wire [7:0]  cfg_code_s;
  wire        prm_ok;
  wire        prm_err;
  wire [7:0]  rise;
  wire        trig_valid;
  wire        trig_del;
  wire        any_err;
  wire        err_rise;
  wire        cpu_ctrl_wr;

  function [7:0] fsd_user_byte;
    input [39:0] u;
    input [2:0]  n;
    begin
      fsd_user_byte = u[8*(n-3'h1) +: 8];
    end
  endfunction

  fsd_sync #(.W(7)) u_sync_ev (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({prm_done, resp_active_in, resp_timeout_in, hw_fail_in,
                xfer_err_in, master_diag_req, cfg_ok_in}),
    .q       (sync_in)
  );

  // Length and count take their own two flops, as deep as those of prm_done, so they arrive together
  fsd_sync #(.W(11)) u_sync_prm (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({prm_len_decl, prm_count}),
    .q       ({prm_len_s, prm_cnt_s})
  );

  fsd_sync #(.W(8)) u_sync_code (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (cfg_err_code),
    .q       (cfg_code_s)
  );

  assign prm_done_s = sync_in[6];
  assign resp_act_s = sync_in[5];
  assign resp_to_s  = sync_in[4];
  assign hw_fail_s  = sync_in[3];
  assign xfer_err_s = sync_in[2];
  assign req_s      = sync_in[1];
  assign cfg_ok_s   = sync_in[0];
  assign cfg_err_s  = cfg_code_s != `FSD_MSG_NONE;

  // Length and count must stay stable while prm_done is high
  assign prm_ok  = prm_done_s && ({1'b0, prm_len_s} == prm_cnt_s)
                   && (prm_cnt_s <= {1'b0, `FSD_PRM_MAX});
  assign prm_err = prm_done_s && !prm_ok;

  fsd_status u_status (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .prm_ok       (prm_ok),
    .prm_err      (prm_err),
    .cfg_ok       (cfg_ok_s),
    .cfg_err      (cfg_err_s),
    .resp_active  (resp_act_s),
    .resp_timeout (resp_to_s),
    .hw_fail      (hw_fail_s),
    .xfer_err     (xfer_err_s),
    .status_clr   (status_clr),
    .status_word  (comm_status),
    .comm_abort   (comm_abort)
  );

  assign any_err     = prm_err | cfg_err_s | comm_abort | hw_fail_s | xfer_err_s;
  assign buf_clear   = any_err;
  assign err_rise    = any_err & ~err_d_reg;
  assign cpu_ctrl_wr = cpu_wr && (cpu_ofs == `FSD_OFS_CTRL);

  // Rising edges of the control byte; any byte with bits 1:0 both set is ignored as a whole
  always @* begin
    ctrl_next = cpu_ctrl_wr ? cpu_wdata : ctrl_reg;
  end
  assign rise       = ctrl_next & ~ctrl_reg;
  assign trig_valid = cpu_ctrl_wr && (cpu_wdata[1:0] != 2'h3)
                      && rise[`FSD_CTRL_VALID];
  assign trig_del   = cpu_ctrl_wr && (cpu_wdata[1:0] != 2'h3)
                      && rise[`FSD_CTRL_DELETE];

  // Message code: errors take priority over the user-valid indication
  always @* begin
    msg_next = msg_reg;
    if (trig_del)
      msg_next = `FSD_MSG_NONE;
    else if (trig_valid)
      msg_next = `FSD_MSG_USER_OK;
    if (prm_err)
      msg_next = `FSD_MSG_PRM_LEN;
    else if (cfg_err_s)
      msg_next = cfg_code_s;
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg  <= `FSD_CTRL_RESET;
      user_reg  <= 40'h00_0000_0000;
      msg_reg   <= `FSD_MSG_NONE;
      pend_reg  <= 1'b0;
      err_d_reg <= 1'b0;
    end else begin
      err_d_reg <= any_err;
      msg_reg   <= msg_next;
      if (cpu_wr && (cpu_ofs == `FSD_OFS_CTRL) && (cpu_wdata[1:0] != 2'h3))
        ctrl_reg <= cpu_wdata;
      if (cpu_wr && (cpu_ofs >= `FSD_OFS_USER) && (cpu_ofs < `FSD_BLOCK_LEN))
        user_reg[8*(cpu_ofs-3'h1) +: 8] <= cpu_wdata;
      if (trig_del)
        user_reg <= 40'h00_0000_0000;
      // Requests collect while a telegram is under way
      if (trig_valid | trig_del | req_s | err_rise)
        pend_reg <= 1'b1;
      else if (state_reg == ST_SEND && !diag_busy)
        pend_reg <= 1'b0;
    end
  end

  // Sequencer: mirror the block into the image, then send the telegram
  always @(posedge clk_sys) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      idx_reg    <= 3'h0;
      img_we     <= 1'b0;
      img_addr   <= {AW{1'b0}};
      img_wdata  <= 8'h00;
      diag_send  <= 1'b0;
      diag_byte6 <= {`FSD_DIAG_CODE, `FSD_DIAG_LEN};
      diag_byte7 <= `FSD_MSG_NONE;
      diag_user  <= 40'h00_0000_0000;
    end else begin
      img_we    <= 1'b0;
      diag_send <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (pend_reg) begin
            idx_reg   <= 3'h0;
            state_reg <= ST_MIRR;
          end
        end
        ST_MIRR: begin
          img_we    <= 1'b1;
          img_addr  <= diag_base + {{(AW-3){1'b0}}, idx_reg};
          img_wdata <= (idx_reg == `FSD_OFS_CTRL) ? ctrl_reg
                       : fsd_user_byte(user_reg, idx_reg);
          if (idx_reg == `FSD_BLOCK_LEN - 3'h1)
            state_reg <= ST_SEND;
          else
            idx_reg <= idx_reg + 3'h1;
        end
        ST_SEND: begin
          if (!diag_busy) begin
            diag_byte6 <= {`FSD_DIAG_CODE, `FSD_DIAG_LEN};
            diag_byte7 <= msg_reg;
            diag_user  <= user_reg;
            diag_send  <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (rst)
      cpu_rdata <= 8'h00;
    else if (cpu_rd)
      cpu_rdata <= (cpu_ofs == `FSD_OFS_CTRL) ? ctrl_reg
                   : (cpu_ofs < `FSD_BLOCK_LEN) ? fsd_user_byte(user_reg, cpu_ofs)
                   : 8'h00;
  end
endmodule // fsd_diag

// File: verif/fsd_diag_sva.sv
// Port assertions for the diagnostics block
`timescale 1ns/1ps
module fsd_diag_sva #(
  parameter AW = 10
) (
  input wire          clk_sys,
  input wire          rst,
  input wire [AW-1:0] diag_base,
  input wire          img_we,
  input wire [AW-1:0] img_addr,
  input wire          diag_send,
  input wire          diag_busy,
  input wire [7:0]    diag_byte6,
  input wire [7:0]    diag_byte7,
  input wire [15:0]   comm_status,
  input wire          comm_abort,
  input wire          buf_clear,
  input wire          resp_active_in,
  input wire          resp_timeout_in,
  input wire          hw_fail_in,
  input wire          xfer_err_in,
  input wire          prm_done,
  input wire [4:0]    prm_len_decl,
  input wire [5:0]    prm_count
);
  reg [2:0] idx_reg;
  always @(posedge clk_sys)
    idx_reg <= (rst || !img_we || idx_reg == 3'h5) ? 3'h0 : idx_reg + 3'h1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_burst;
    img_we [*6] ##1 !img_we;
  endsequence
  sequence s_tx;
    ##[0:60] diag_send;
  endsequence
  property p_len;
    diag_byte6[5:0] == 6'h0A;
  endproperty
  a_len: assert property (p_len) else $error("length field wrong");
  property p_code;
    diag_byte6[7:6] == 2'h0;
  endproperty
  a_code: assert property (p_code) else $error("code field wrong");
  property p_msg;
    diag_send |-> diag_byte7 inside {8'h00, [8'h12:8'h17], 8'h40};
  endproperty
  a_msg: assert property (p_msg) else $error("bad message code");
  property p_burst;
    $rose(img_we) |-> s_burst;
  endproperty
  a_burst: assert property (p_burst) else $error("block not six bytes");
  property p_addr;
    img_we |-> img_addr == diag_base + {{(AW-3){1'b0}}, idx_reg};
  endproperty
  a_addr: assert property (p_addr) else $error("block address wrong");
  property p_send;
    $fell(img_we) |-> s_tx;
  endproperty
  a_send: assert property (p_send) else $error("telegram not sent");
  property p_busy;
    diag_send |-> !$past(diag_busy) ##1 !diag_send;
  endproperty
  a_busy: assert property (p_busy) else $error("send while busy");
  property p_clear;
    buf_clear |=> comm_status[0];
  endproperty
  a_clear: assert property (p_clear) else $error("clear bit missing");
  property p_wdog;
    (resp_active_in && resp_timeout_in) [*5] |-> comm_abort && comm_status[11];
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog not seen");
  property p_hw;
    hw_fail_in [*5] |-> comm_status[12];
  endproperty
  a_hw: assert property (p_hw) else $error("hardware bit missing");
  property p_xfer;
    xfer_err_in [*5] |-> comm_status[13];
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer bit missing");
  property p_prm;
    (prm_done && prm_count != {1'b0, prm_len_decl}) [*5] |-> comm_status[9];
  endproperty
  a_prm: assert property (p_prm) else $error("parameter bit missing");
endmodule // fsd_diag_sva
bind fsd_diag fsd_diag_sva #(.AW(AW)) u_sva (
  .clk_sys         (clk_sys),
  .rst             (rst),
  .diag_base       (diag_base),
  .img_we          (img_we),
  .img_addr        (img_addr),
  .diag_send       (diag_send),
  .diag_busy       (diag_busy),
  .diag_byte6      (diag_byte6),
  .diag_byte7      (diag_byte7),
  .comm_status     (comm_status),
  .comm_abort      (comm_abort),
  .buf_clear       (buf_clear),
  .resp_active_in  (resp_active_in),
  .resp_timeout_in (resp_timeout_in),
  .hw_fail_in      (hw_fail_in),
  .xfer_err_in     (xfer_err_in),
  .prm_done        (prm_done),
  .prm_len_decl    (prm_len_decl),
  .prm_count       (prm_count)
);

// File: verif/fsd_master_model.sv
// Behavioural fieldbus master taking diagnostic telegrams
`timescale 1ns/1ps
module fsd_master_model (
  input  wire clk_sys,
  input  wire rst,
  input  wire slow,
  input  wire diag_send,
  output reg  diag_busy
);
  reg [3:0] hold_reg;
  always @(posedge clk_sys) begin
    if (rst) begin
      diag_busy <= 1'b0;
      hold_reg  <= 4'h0;
    end else if (diag_send) begin
      diag_busy <= 1'b1;
      hold_reg  <= slow ? 4'h8 : 4'h1;
    end else if (hold_reg != 4'h0) begin
      hold_reg <= hold_reg - 4'h1;
    end else begin
      diag_busy <= 1'b0;
    end
  end
endmodule // fsd_master_model

// File: verif/test_fieldbus_slave_diagnostics.sv
// Self-checking bench for the diagnostics block
`timescale 1ns/1ps
module test_fieldbus_slave_diagnostics;
  reg clk_sys = 0, rst = 1, cpu_wr = 0, cpu_rd = 0, status_clr = 0, prm_done = 0;
  reg cfg_ok_in = 0, resp_active_in = 0, resp_timeout_in = 0, hw_fail_in = 0;
  reg xfer_err_in = 0, master_diag_req = 0, slow = 0, img_chk = 0;
  reg [2:0] cpu_ofs = 0;
  reg [7:0] cpu_wdata = 0, cfg_err_code = 0;
  reg [9:0] diag_base = 10'h3FC;
  reg [4:0] prm_len_decl = 0;
  reg [5:0] prm_count = 0;
  reg [39:0] uv = 0;
  wire [7:0] cpu_rdata, img_wdata, diag_byte6, diag_byte7;
  wire [15:0] comm_status;
  wire [9:0] img_addr;
  wire [39:0] diag_user;
  wire img_we, diag_send, diag_busy, comm_abort, buf_clear;
  integer err_count = 0, n_checks = 0, sends = 0, idx = 0, ctrl = 0, exp7 = -1, i;
  reg [31:0] seed = 20864;
  fsd_diag u_dut (.clk_sys(clk_sys), .rst(rst), .cpu_wr(cpu_wr), .cpu_ofs(cpu_ofs),
    .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
    .comm_status(comm_status), .status_clr(status_clr), .diag_base(diag_base),
    .img_we(img_we), .img_addr(img_addr), .img_wdata(img_wdata), .prm_done(prm_done),
    .prm_len_decl(prm_len_decl), .prm_count(prm_count), .cfg_ok_in(cfg_ok_in),
    .cfg_err_code(cfg_err_code), .resp_active_in(resp_active_in),
    .resp_timeout_in(resp_timeout_in), .hw_fail_in(hw_fail_in),
    .xfer_err_in(xfer_err_in), .master_diag_req(master_diag_req),
    .diag_send(diag_send), .diag_busy(diag_busy), .diag_byte6(diag_byte6),
    .diag_byte7(diag_byte7), .diag_user(diag_user), .comm_abort(comm_abort),
    .buf_clear(buf_clear));
  fsd_master_model u_master (.clk_sys(clk_sys), .rst(rst), .slow(slow),
    .diag_send(diag_send), .diag_busy(diag_busy));
  always #2 clk_sys = ~clk_sys;
  function [31:0] xs;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    xs = seed;
  endfunction
  task automatic chk(input [47:0] seen, input [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task do_reset;
    @(posedge clk_sys);
    rst <= 1;
    {prm_done, resp_active_in, resp_timeout_in, hw_fail_in, xfer_err_in} <= 0;
    cfg_err_code <= 0;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    sends = 0;
    uv = 0;
  endtask
  task wr(input [2:0] o, input [7:0] d);
    @(posedge clk_sys);
    cpu_wr <= 1;
    cpu_ofs <= o;
    cpu_wdata <= d;
    @(posedge clk_sys);
    cpu_wr <= 0;
  endtask
  task rd(input [2:0] o, input [7:0] e);
    @(posedge clk_sys);
    cpu_rd <= 1;
    cpu_ofs <= o;
    @(posedge clk_sys);
    cpu_rd <= 0;
    #1 chk(cpu_rdata, e);
  endtask
  task wsend(input integer n);
    repeat (80) if (sends < n) @(posedge clk_sys) #1;
    chk(sends, n);
  endtask
  task st(input integer b, input e);
    repeat (5) @(posedge clk_sys);
    #1 chk(comm_status[b], e);
  endtask
  task fill;
    for (i = 0; i < 5; i++) begin
      uv[8*i+:8] = 8'(xs());
      wr(i + 1, uv[8*i+:8]);
    end
  endtask
  always @(posedge clk_sys) begin
    if (img_we) begin
      chk(img_addr, 10'(diag_base + idx));
      if (img_chk) chk(img_wdata, idx == 0 ? ctrl : uv[8*idx-8+:8]);
      idx = (idx == 5) ? 0 : idx + 1;
    end else
      idx = 0;
    if (diag_send) begin
      sends++;
      if (exp7 >= 0) chk({diag_byte7, diag_user}, {exp7[7:0], uv});
    end
  end
  initial begin
    #40000 err_count++;
    end_of_test;
  end
  initial begin
    do_reset;
    #1 chk(diag_byte6, 8'h0A);
    fill;
    img_chk = 1;
    exp7 = 'h40;
    ctrl = 1;
    wr(0, 8'h01);
    wsend(1);
    wr(0, 8'h03);
    repeat (20) @(posedge clk_sys);
    chk(sends, 1);
    rd(0, 8'h01);
    rd(6, 8'h00);
    rd(3, uv[23:16]);
    slow <= 1;
    diag_base <= 10'(xs());
    {img_chk, ctrl, exp7, uv} = 0;
    wr(0, 8'h02);
    wsend(2);
    fill;
    {img_chk, ctrl, exp7} = {1'b1, 32'd1, 32'h40};
    wr(0, 8'h01);
    wsend(3);
    master_diag_req <= 1;
    wsend(4);
    master_diag_req <= 0;
    img_chk = 0;
    for (integer k = 0; k < 6; k++) begin
      do_reset;
      exp7 = 'h12 + k;
      if (k == 0) {prm_len_decl, prm_count, prm_done} <= {5'h03, 6'h04, 1'b1};
      else cfg_err_code <= 8'(exp7);
      wsend(1);
      st(k == 0 ? 9 : 10, 1);
      st(8, 1);
      chk(comm_abort, 1);
    end
    do_reset;
    exp7 = -1;
    cfg_ok_in <= 1;
    {prm_len_decl, prm_count, prm_done} <= {5'h1F, 6'h1F, 1'b1};
    st(2, 1);
    st(9, 0);
    resp_active_in <= 1;
    st(3, 1);
    resp_timeout_in <= 1;
    st(11, 1);
    chk(comm_abort, 1);
    hw_fail_in <= 1;
    st(12, 1);
    xfer_err_in <= 1;
    st(13, 1);
    chk(comm_status[0], 1);
    {resp_active_in, resp_timeout_in, hw_fail_in, xfer_err_in} <= 0;
    repeat (4) @(posedge clk_sys);
    status_clr <= 1;
    @(posedge clk_sys);
    status_clr <= 0;
    st(13, 0);
    end_of_test;
  end
endmodule // test_fieldbus_slave_diagnostics
